// *** shared/cic_pkg.sv ***
// Package of constants and types for the interrupt control unit
package cic_pkg;
	localparam int CIC_MASK_W = 12;
	localparam int CIC_CHANS = 8;
	localparam int CIC_LINES = 64;
	// Mask bit positions
	localparam int CIC_MB_RTC = 8;
	localparam int CIC_MB_EXPDEC = 9;
	localparam int CIC_MB_ARITH = 10;
	localparam int CIC_MB_SRCH = 11;
	localparam logic [11:0] CIC_MASK_RESET = 12'h000;
	// Exponent limits, octal 1777
	localparam logic signed [12:0] CIC_EXP_MAX = 13'sd1023;
	localparam logic signed [12:0] CIC_EXP_MIN = -13'sd1023;
	localparam logic [5:0] CIC_DEC_BAD0 = 6'o15;
	localparam logic [5:0] CIC_DEC_BAD1 = 6'o16;
	localparam logic [5:0] CIC_DEC_BAD2 = 6'o17;
	localparam logic [3:0] CIC_DIGIT_MAX = 4'h9;
	localparam logic [5:0] CIC_TRAP_LO = 6'o55;
	localparam logic [5:0] CIC_TRAP_HI = 6'o70;
	// Vector addresses
	localparam logic [14:0] CIC_PF_SAVE = 15'o00002;
	localparam logic [14:0] CIC_PF_JUMP = 15'o00003;
	localparam logic [14:0] CIC_INT_SAVE = 15'o00004;
	localparam logic [14:0] CIC_INT_JUMP = 15'o00005;
	localparam logic [14:0] CIC_TRAP_SAVE = 15'o00010;
	localparam logic [14:0] CIC_TRAP_JUMP = 15'o00011;
	// Condition codes
	localparam logic [11:0] CIC_CODE_RTC = 12'o0110;
	localparam logic [11:0] CIC_CODE_OVF = 12'o0111;
	localparam logic [11:0] CIC_CODE_DIV = 12'o0112;
	localparam logic [11:0] CIC_CODE_EXP = 12'o0113;
	localparam logic [11:0] CIC_CODE_DEC = 12'o0114;
	localparam logic [11:0] CIC_CODE_SRCH = 12'o0115;
	localparam logic [11:0] CIC_CODE_MAN = 12'o0116;
	localparam logic [11:0] CIC_CODE_NBR = 12'o0117;
	localparam logic [11:0] CIC_CODE_CHAN = 12'o0100;
	// Power timing
	localparam int CIC_CLK_HZ = 25_000_000;
	localparam int CIC_PF_DET_MS = 16;
	localparam int CIC_PF_RUN_MS = 4;
	localparam int CIC_PF_DET_CYC = CIC_CLK_HZ / 1000 * CIC_PF_DET_MS;
	localparam int CIC_PF_RUN_CYC = CIC_CLK_HZ / 1000 * CIC_PF_RUN_MS;
	// Entry kinds written to storage
	typedef enum logic [1:0] {
		CIC_ENT_NONE = 2'b00,
		CIC_ENT_INT = 2'b01,
		CIC_ENT_TRAP = 2'b11,
		CIC_ENT_PF = 2'b10
	} cic_entry_t;
	// Instruction strobes from the sequencer, one-cycle pulses
	typedef struct packed {
		logic enableIrq;
		logic disableIrq;
		logic setMask;
		logic clearMask;
		logic senseIrq;
		logic clearIrq;
		logic clearIo;
		logic copyStatus;
	} cic_instr_t;
	// Internal fault and completion events, one-cycle pulses
	typedef struct packed {
		logic arithOvf;
		logic divide;
		logic floatOp;
		logic decimalOp;
		logic decLoad;
		logic searchDone;
		logic moveDone;
		logic srchEnable;
	} cic_event_t;
	// Entry request to the sequencer
	typedef struct packed {
		cic_entry_t kind;
		logic [14:0] saveAddr;
		logic [14:0] saveData;
		logic [14:0] jumpAddr;
		logic [11:0] code;
	} cic_entry_req_t;
endpackage : cic_pkg

// *** hw/cic_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module cic_sync
	import cic_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Only stage2 reads stage1; output changes when stages 2 and 3 agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= asyncIn;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					syncOut[i] <= stage3[i];
				end
			end
		end
	end
endmodule : cic_sync

// *** hw/cic_fault_check.sv ***
// Arithmetic fault detection for floating and decimal operands
`timescale 1ns/1ns
module cic_fault_check
	import cic_pkg::*;
(
	// Operation context
	input wire logic floatOp,
	input wire logic decimalOp,
	input wire logic decLoad,
	input wire logic signed [12:0] exponent,
	input wire logic [23:0] decOperand,
	input wire logic [5:0] decLoadValue,
	// Results
	output logic expFault,
	output logic decFault,
	output logic [23:0] decFixed
);
	logic [2:0] badChar;

	// Exponent range test
	assign expFault = floatOp &&
		(exponent > CIC_EXP_MAX || exponent < CIC_EXP_MIN);

	// Upper three characters checked; least significant one is exempt
	genvar g;
	generate
		for (g = 1; g < 4; g++) begin : gChar
			logic digitBad;
			assign digitBad = decOperand[g*6 +: 4] > CIC_DIGIT_MAX;
			assign badChar[g-1] = decimalOp &&
				(digitBad || decOperand[g*6+4 +: 2] != 2'b00);
			// Illegal digit replaced by zero
			assign decFixed[g*6 +: 6] = (decimalOp && digitBad) ?
				6'h00 : decOperand[g*6 +: 6];
		end
	endgenerate
	assign decFixed[5:0] = decOperand[5:0];

	assign decFault = (|badChar) || (decLoad &&
		(decLoadValue == CIC_DEC_BAD0 || decLoadValue == CIC_DEC_BAD1 ||
		decLoadValue == CIC_DEC_BAD2));
endmodule : cic_fault_check

// *** hw/cic_top.sv ***
// Interrupt control unit: latches, mask, enable, priority, entry
`timescale 1ns/1ns
module cic_top
	import cic_pkg::*;
#(
	parameter int PF_DET_CYC = CIC_PF_DET_CYC,
	parameter int PF_RUN_CYC = CIC_PF_RUN_CYC,
	parameter logic [7:0] CHAN_PRESENT = 8'hFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Instruction strobes and operand
	input wire cic_instr_t instr,
	input wire logic [11:0] maskOperand,
	input wire logic fetchEnd,
	input wire logic [14:0] progAddr,
	input wire logic [5:0] opcode,
	input wire logic [7:0] optionPresent,
	// Internal events and fault operands
	input wire cic_event_t events,
	input wire logic signed [12:0] exponent,
	input wire logic [23:0] decOperand,
	input wire logic [5:0] decLoadValue,
	// Real-time clock
	input wire logic [23:0] rtcValue,
	input wire logic [23:0] rtcTarget,
	// Channels and equipment
	input wire logic [7:0] chanEvent,
	input wire logic [7:0] chanIrqArm,
	input wire logic [63:0] equipIrq,
	input wire logic [7:0] selectClear,
	input wire logic externalClear,
	input wire logic internalClear,
	// Console, neighbour and power, asynchronous pins
	input wire logic manualSwitch,
	input wire logic neighbourIrq,
	input wire logic powerOk,
	// Outputs to sequencer
	output cic_entry_req_t entryReq,
	output logic entryValid,
	output logic [11:0] maskCopy,
	output logic [11:0] senseResult,
	output logic [23:0] decFixedOut,
	output logic irqEnabled,
	output logic powerDown
);
	logic [11:0] maskBits;
	logic [7:0] chanLatch;
	logic [63:0] equipLatch;
	logic ovfLatch, divLatch, expLatch, decLatch, srchLatch, rtcLatch;
	logic manLatch, nbrLatch;
	logic enablePending;
	logic expFault, decFault;
	logic [23:0] decFixed;
	logic manSync, nbrSync, pwrSync;
	logic manPrev, nbrPrev;
	logic [24:0] pfCount;
	logic pfActive, pfTaken;
	logic [23:0] rtcPrev;
	logic trapHit;
	logic [7:0] chanActive;
	logic [63:0] equipActive;
	logic [7:0] chanGate;
	logic [11:0] senseSel;
	logic nextValid;
	cic_entry_req_t nextReq;
	logic [5:0] equipIdx;
	logic [2:0] chanIdx;
	logic equipAny, chanAny;
	logic takeInt, takeTrap, takePf;

	cic_sync #(.W(3)) uSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.asyncIn({manualSwitch, neighbourIrq, powerOk}),
		.syncOut({manSync, nbrSync, pwrSync})
	);

	cic_fault_check uFault (
		.floatOp(events.floatOp),
		.decimalOp(events.decimalOp),
		.decLoad(events.decLoad),
		.exponent(exponent),
		.decOperand(decOperand),
		.decLoadValue(decLoadValue),
		.expFault(expFault),
		.decFault(decFault),
		.decFixed(decFixed)
	);

	// Sense and clear selection use the mask-format operand
	assign senseSel = instr.senseIrq ? maskOperand : 12'h000;
	// Channel gate: mask bit per channel, absent channels can never pass
	assign chanGate = maskBits[7:0] & CHAN_PRESENT;
	assign chanActive = chanLatch & chanGate;
	// Equipment line index = line*8 + channel
	generate
		for (genvar c = 0; c < CIC_CHANS; c++) begin : gEq
			for (genvar l = 0; l < 8; l++) begin : gLn
				assign equipActive[l*8+c] = equipLatch[l*8+c] && chanGate[c];
			end
		end
	endgenerate

	// Lowest set index wins inside each group
	always_comb begin
		equipIdx = 6'd0;
		equipAny = 1'b0;
		chanIdx = 3'd0;
		chanAny = 1'b0;
		for (int i = CIC_LINES - 1; i >= 0; i--) begin
			if (equipActive[i]) begin
				equipIdx = 6'(i);
				equipAny = 1'b1;
			end
		end
		for (int i = CIC_CHANS - 1; i >= 0; i--) begin
			if (chanActive[i]) begin
				chanIdx = 3'(i);
				chanAny = 1'b1;
			end
		end
	end

	assign trapHit = opcode >= CIC_TRAP_LO && opcode <= CIC_TRAP_HI &&
		!optionPresent[3'(opcode - CIC_TRAP_LO)];

	// Priority scan, restarted from the top at each fetch test
	always_comb begin
		nextValid = 1'b0;
		nextReq = '0;
		nextReq.kind = CIC_ENT_INT;
		nextReq.saveAddr = CIC_INT_SAVE;
		nextReq.saveData = progAddr;
		nextReq.jumpAddr = CIC_INT_JUMP;
		if (pfActive && !pfTaken) begin
			nextValid = 1'b1;
			nextReq.kind = CIC_ENT_PF;
			nextReq.saveAddr = CIC_PF_SAVE;
			nextReq.jumpAddr = CIC_PF_JUMP;
		end else if (irqEnabled) begin
			nextValid = 1'b1;
			if ((ovfLatch || divLatch) && maskBits[CIC_MB_ARITH]) begin
				nextReq.code = ovfLatch ? CIC_CODE_OVF : CIC_CODE_DIV;
			end else if ((expLatch || decLatch) && maskBits[CIC_MB_EXPDEC]) begin
				nextReq.code = expLatch ? CIC_CODE_EXP : CIC_CODE_DEC;
			end else if (equipAny) begin
				nextReq.code = {6'h00, equipIdx};
			end else if (chanAny) begin
				nextReq.code = CIC_CODE_CHAN | {9'h000, chanIdx};
			end else if (srchLatch && maskBits[CIC_MB_SRCH]) begin
				nextReq.code = CIC_CODE_SRCH;
			end else if (rtcLatch && maskBits[CIC_MB_RTC]) begin
				nextReq.code = CIC_CODE_RTC;
			end else if (manLatch) begin
				nextReq.code = CIC_CODE_MAN;
			end else if (nbrLatch) begin
				nextReq.code = CIC_CODE_NBR;
			end else begin
				nextValid = 1'b0;
			end
		end
		// A trap runs only when no normal interrupt is taken
		if (!nextValid && trapHit) begin
			nextValid = 1'b1;
			nextReq.kind = CIC_ENT_TRAP;
			nextReq.saveAddr = CIC_TRAP_SAVE;
			nextReq.saveData = progAddr + 15'h0001;
			nextReq.jumpAddr = CIC_TRAP_JUMP;
			nextReq.code = {6'h00, opcode};
		end
	end

	assign takePf = fetchEnd && nextValid && nextReq.kind == CIC_ENT_PF;
	assign takeInt = fetchEnd && nextValid && nextReq.kind == CIC_ENT_INT;
	assign takeTrap = fetchEnd && nextValid && nextReq.kind == CIC_ENT_TRAP;

	// Entry request, registered and presented in the cycle after fetch end only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			entryReq <= '0;
			entryValid <= 1'b0;
		end else begin
			entryValid <= fetchEnd && nextValid;
			entryReq <= nextReq;
		end
	end

	// Mask register: selective set and clear, absent channels stay zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			maskBits <= CIC_MASK_RESET;
		end else if (instr.setMask) begin
			maskBits <= (maskBits | maskOperand) &
				{4'hF, CHAN_PRESENT};
		end else if (instr.clearMask) begin
			maskBits <= maskBits & ~maskOperand;
		end
	end

	// Copy instructions return the mask for the accumulator's upper bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			maskCopy <= 12'h000;
		end else if (instr.copyStatus) begin
			maskCopy <= maskBits;
		end
	end

	// Global enable; enable is delayed by one further instruction fetch
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqEnabled <= 1'b0;
			enablePending <= 1'b0;
		end else if (takePf || takeInt || takeTrap || instr.disableIrq) begin
			irqEnabled <= 1'b0;
			enablePending <= 1'b0;
		end else if (instr.enableIrq) begin
			enablePending <= 1'b1;
		end else if (enablePending && fetchEnd) begin
			irqEnabled <= 1'b1;
			enablePending <= 1'b0;
		end
	end

	// Internal condition latches; a new event beats a same-cycle clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ovfLatch <= 1'b0;
			divLatch <= 1'b0;
			expLatch <= 1'b0;
			decLatch <= 1'b0;
			srchLatch <= 1'b0;
			rtcLatch <= 1'b0;
			rtcPrev <= 24'h0000_00;
		end else begin
			rtcPrev <= rtcValue;
			ovfLatch <= events.arithOvf || (ovfLatch && !internalClear &&
				!(takeInt && nextReq.code == CIC_CODE_OVF) &&
				!senseSel[CIC_MB_ARITH] &&
				!(instr.clearIrq && maskOperand[CIC_MB_ARITH]));
			divLatch <= events.divide || (divLatch && !internalClear &&
				!(takeInt && nextReq.code == CIC_CODE_DIV) &&
				!senseSel[CIC_MB_ARITH] &&
				!(instr.clearIrq && maskOperand[CIC_MB_ARITH]));
			expLatch <= expFault || (expLatch && !internalClear &&
				!(takeInt && nextReq.code == CIC_CODE_EXP) &&
				!senseSel[CIC_MB_EXPDEC] &&
				!(instr.clearIrq && maskOperand[CIC_MB_EXPDEC]));
			decLatch <= decFault || (decLatch && !internalClear &&
				!(takeInt && nextReq.code == CIC_CODE_DEC) &&
				!senseSel[CIC_MB_EXPDEC] &&
				!(instr.clearIrq && maskOperand[CIC_MB_EXPDEC]));
			srchLatch <= (events.srchEnable &&
				(events.searchDone || events.moveDone)) || (srchLatch &&
				!internalClear && !(takeInt && nextReq.code == CIC_CODE_SRCH) &&
				!senseSel[CIC_MB_SRCH] &&
				!(instr.clearIrq && maskOperand[CIC_MB_SRCH]));
			// Edge on equality so a held match does not refire after a clear
			rtcLatch <= (rtcValue == rtcTarget && rtcPrev != rtcTarget) ||
				(rtcLatch && !internalClear &&
				!(takeInt && nextReq.code == CIC_CODE_RTC) &&
				!senseSel[CIC_MB_RTC] &&
				!(instr.clearIrq && maskOperand[CIC_MB_RTC]));
		end
	end

	// Channel interrupts: cleared only by interrupt clear or I/O clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chanLatch <= 8'h00;
		end else begin
			chanLatch <= (chanEvent & chanIrqArm) | (chanLatch &
				~(instr.clearIrq ? maskOperand[7:0] : 8'h00) &
				~{8{instr.clearIo}});
		end
	end

	// Equipment lines follow the controller; held until it cancels or an I/O clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			equipLatch <= 64'h0000_0000_0000_0000;
		end else begin
			for (int i = 0; i < CIC_LINES; i++) begin
				equipLatch[i] <= equipIrq[i] || (equipLatch[i] &&
					!externalClear && !instr.clearIo &&
					!selectClear[i % 8]);
			end
		end
	end

	// Manual and neighbour: rising edges latched, cleared on recognition
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			manPrev <= 1'b0;
			nbrPrev <= 1'b0;
			manLatch <= 1'b0;
			nbrLatch <= 1'b0;
		end else begin
			manPrev <= manSync;
			nbrPrev <= nbrSync;
			manLatch <= (manSync && !manPrev) || (manLatch &&
				!(takeInt && nextReq.code == CIC_CODE_MAN));
			nbrLatch <= (nbrSync && !nbrPrev) || (nbrLatch &&
				!(takeInt && nextReq.code == CIC_CODE_NBR));
		end
	end

	// Sense result ignores the mask; absent channels read active
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			senseResult <= 12'h000;
		end else if (instr.senseIrq) begin
			senseResult <= {srchLatch, ovfLatch || divLatch,
				expLatch || decLatch, rtcLatch,
				chanLatch | ~CHAN_PRESENT};
		end
	end

	// Decimal operand with illegal digits replaced
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			decFixedOut <= 24'h0000_00;
		end else begin
			decFixedOut <= decFixed;
		end
	end

	// Power failure: detection window, then routine window before halt
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pfCount <= 25'h000_0000;
			pfActive <= 1'b0;
			pfTaken <= 1'b0;
			powerDown <= 1'b0;
		end else if (pwrSync && !pfActive) begin
			pfCount <= 25'h000_0000;
		end else if (!pfActive) begin
			pfCount <= pfCount + 25'h000_0001;
			if (pfCount == 25'(PF_DET_CYC - 1)) begin
				pfActive <= 1'b1;
				pfCount <= 25'h000_0000;
			end
		end else begin
			if (takePf) begin
				pfTaken <= 1'b1;
			end
			if (pfCount != 25'(PF_RUN_CYC - 1)) begin
				pfCount <= pfCount + 25'h000_0001;
			end else begin
				powerDown <= 1'b1;
			end
		end
	end
endmodule : cic_top

// *** verification/cic_top_props.sv ***
// Checker of entry, enable and sense behaviour at the unit's ports
`timescale 1ns/1ns
module cic_top_props
	import cic_pkg::*;
#(
	parameter logic [7:0] CHAN_PRESENT = 8'hFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Sequencer side
	input wire cic_instr_t instr,
	input wire logic fetchEnd,
	input wire logic [14:0] progAddr,
	input wire cic_entry_req_t entryReq,
	input wire logic entryValid,
	input wire logic [11:0] senseResult,
	input wire logic irqEnabled
);
	logic fetchSeen;
	logic isInt;
	logic isTrap;
	logic isPf;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Entry kinds decoded once
	assign isInt = entryValid && entryReq.kind == CIC_ENT_INT;
	assign isTrap = entryValid && entryReq.kind == CIC_ENT_TRAP;
	assign isPf = entryValid && entryReq.kind == CIC_ENT_PF;
	// A fetch seen since enable was asked; the next fetch must not interrupt
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			fetchSeen <= 1'b0;
		else if (instr.enableIrq && !irqEnabled)
			fetchSeen <= 1'b0;
		else if (fetchEnd)
			fetchSeen <= 1'b1;
	end
	entry_on_fetch_a: assert property (entryValid && !isPf |-> $past(fetchEnd))
		else $error("entry without fetch end");
	enable_delay_a: assert property (isInt |-> $past(fetchSeen))
		else $error("interrupt before enable took effect");
	entry_disables_a: assert property (isInt |-> !irqEnabled)
		else $error("enable still set after entry");
	pf_disables_a: assert property (isPf |-> !irqEnabled)
		else $error("enable still set after power entry");
	int_vector_a: assert property (isInt |-> entryReq.saveAddr == CIC_INT_SAVE
		&& entryReq.jumpAddr == CIC_INT_JUMP && entryReq.saveData == $past(progAddr))
		else $error("bad interrupt vector");
	trap_vector_a: assert property (isTrap |-> entryReq.saveAddr == CIC_TRAP_SAVE
		&& entryReq.jumpAddr == CIC_TRAP_JUMP
		&& entryReq.saveData == $past(progAddr) + 15'h0001)
		else $error("bad trap vector");
	pf_vector_a: assert property (isPf |-> entryReq.saveAddr == CIC_PF_SAVE
		&& entryReq.jumpAddr == CIC_PF_JUMP) else $error("bad power vector");
	enable_set_a: assert property (instr.enableIrq && !irqEnabled
		|=> !irqEnabled) else $error("enable took effect at once");
	disable_clr_a: assert property (instr.disableIrq |=> !irqEnabled)
		else $error("enable not cleared");
	absent_chan_a: assert property (instr.senseIrq |=>
		(senseResult[7:0] & ~CHAN_PRESENT) == ~CHAN_PRESENT)
		else $error("absent channel not sensed active");
	code_range_a: assert property (isInt |-> entryReq.code <= CIC_CODE_NBR)
		else $error("interrupt code out of range");
endmodule : cic_top_props

// *** verification/cic_seq_model.sv ***
// Sequencer storage model: performs the stores that an entry asks for
`timescale 1ns/1ns
module cic_seq_model
	import cic_pkg::*;
#(
	parameter logic [23:0] FILL = 24'h00_0000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Entry request from the unit
	input wire cic_entry_req_t entryReq,
	input wire logic entryValid
);
	logic [23:0] mem [0:15];
	// Low storage only; upper bits of vector words must survive entries
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++)
				mem[i] <= FILL;
		end else if (entryValid) begin
			mem[entryReq.saveAddr[3:0]][14:0] <= entryReq.saveData;
			if (entryReq.kind == CIC_ENT_INT)
				mem[entryReq.jumpAddr[3:0]][11:0] <= entryReq.code;
			else if (entryReq.kind == CIC_ENT_TRAP)
				mem[entryReq.jumpAddr[3:0]][5:0] <= entryReq.code[5:0];
		end
	end
endmodule : cic_seq_model

// *** verification/tb_top.sv ***
// Testbench of the interrupt control unit
`timescale 1ns/1ns
module tb_top;
	import cic_pkg::*;
	localparam logic [7:0] CHAN_PRESENT = 8'h7F;
	localparam logic [23:0] FILL = 24'hAB_CDEF;
	localparam logic [7:0] I_EN = 8'h80;
	localparam logic [7:0] I_DIS = 8'h40;
	localparam logic [7:0] I_SET = 8'h20;
	localparam logic [7:0] I_CLR = 8'h10;
	localparam logic [7:0] I_SENSE = 8'h08;
	localparam logic [7:0] I_CLRIRQ = 8'h04;
	localparam logic [7:0] I_COPY = 8'h01;
	logic mclk, rst_n, fetchEnd, got;
	cic_instr_t instr;
	cic_event_t events;
	logic [11:0] maskOperand, maskCopy, senseResult;
	logic [14:0] progAddr;
	logic [5:0] opcode, decLoadValue;
	logic [7:0] optionPresent, chanEvent, chanIrqArm, selectClear;
	logic signed [12:0] exponent;
	logic [23:0] decOperand, rtcValue, rtcTarget, decFixedOut;
	logic [63:0] equipIrq;
	logic externalClear, internalClear, manualSwitch, neighbourIrq, powerOk;
	cic_entry_req_t entryReq, req;
	logic entryValid, irqEnabled, powerDown;
	int err_total, samples_checked, n;
	// Short counts keep the power sequence within the run
	cic_top #(.PF_DET_CYC(20), .PF_RUN_CYC(10), .CHAN_PRESENT(CHAN_PRESENT))
	dut_u (.mclk(mclk), .rst_n(rst_n), .instr(instr), .maskOperand(maskOperand),
		.fetchEnd(fetchEnd), .progAddr(progAddr), .opcode(opcode),
		.optionPresent(optionPresent), .events(events), .exponent(exponent),
		.decOperand(decOperand), .decLoadValue(decLoadValue),
		.rtcValue(rtcValue), .rtcTarget(rtcTarget), .chanEvent(chanEvent),
		.chanIrqArm(chanIrqArm), .equipIrq(equipIrq), .selectClear(selectClear),
		.externalClear(externalClear), .internalClear(internalClear),
		.manualSwitch(manualSwitch), .neighbourIrq(neighbourIrq),
		.powerOk(powerOk), .entryReq(entryReq), .entryValid(entryValid),
		.maskCopy(maskCopy), .senseResult(senseResult),
		.decFixedOut(decFixedOut), .irqEnabled(irqEnabled),
		.powerDown(powerDown));
	cic_seq_model #(.FILL(FILL)) seq_u (.mclk(mclk), .rst_n(rst_n),
		.entryReq(entryReq), .entryValid(entryValid));
	// Clock, 40 ns period
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task chk(input logic [23:0] g, input logic [23:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Strobes last one cycle and are driven at the falling edge
	task pulse(input logic [7:0] s, input logic [11:0] op);
		@(negedge mclk);
		instr = s;
		maskOperand = op;
		@(negedge mclk);
		instr = '0;
	endtask : pulse
	// One fetch end; an entry answers in the following cycle only
	task fetch();
		@(negedge mclk);
		fetchEnd = 1'b1;
		@(negedge mclk);
		fetchEnd = 1'b0;
		got = entryValid;
		req = entryReq;
	endtask : fetch
	task hold(input int c);
		repeat (c) @(negedge mclk);
	endtask : hold
	task service(input logic [11:0] code);
		pulse(I_EN, 12'h000);
		fetch();
		chk(got, 1'b0);
		fetch();
		chk(got, 1'b1);
		chk(req.kind, CIC_ENT_INT);
		chk(req.code, code);
		chk(irqEnabled, 1'b0);
		@(negedge mclk);
		chk(seq_u.mem[5], {FILL[23:12], code});
		chk(seq_u.mem[4][14:0], progAddr);
	endtask : service
	task quiet();
		pulse(I_EN, 12'h000);
		fetch();
		fetch();
		chk(got, 1'b0);
		pulse(I_DIS, 12'h000);
		chk(irqEnabled, 1'b0);
	endtask : quiet
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		wrap_up();
	end
	// Main sequence
	initial begin
		{rst_n, fetchEnd, instr, maskOperand, opcode, optionPresent} = '0;
		{events, exponent, decOperand, decLoadValue, rtcValue} = '0;
		{chanEvent, equipIrq, selectClear, externalClear, internalClear} = '0;
		{manualSwitch, neighbourIrq} = '0;
		progAddr = 15'h029C;
		rtcTarget = 24'h00_0100;
		chanIrqArm = 8'hFF;
		powerOk = 1'b1;
		hold(10);
		rst_n = 1'b1;
		pulse(I_COPY, 12'h000);
		chk(maskCopy, CIC_MASK_RESET);
		chk(irqEnabled, 1'b0);
		$display("test reset done");
		pulse(I_SET, 12'hFFF);
		pulse(I_COPY, 12'h000);
		chk(maskCopy, {4'hF, CHAN_PRESENT});
		pulse(I_CLR, 12'h0F0);
		pulse(I_COPY, 12'h000);
		chk(maskCopy, {4'hF, CHAN_PRESENT & 8'h0F});
		pulse(I_CLR, 12'hFFF);
		$display("test mask done");
		rtcValue = rtcTarget;
		hold(1);
		rtcValue = 24'h00_0000;
		quiet();
		pulse(I_SENSE, 12'h100);
		chk(senseResult, 12'h180);
		pulse(I_SENSE, 12'h100);
		chk(senseResult, 12'h080);
		$display("test sense done");
		manualSwitch = 1'b1;
		hold(6);
		manualSwitch = 1'b0;
		hold(6);
		service(CIC_CODE_MAN);
		quiet();
		neighbourIrq = 1'b1;
		hold(6);
		neighbourIrq = 1'b0;
		hold(6);
		service(CIC_CODE_NBR);
		quiet();
		$display("test unmasked done");
		pulse(I_SET, 12'hFFF);
		{events.arithOvf, events.divide} = 2'b11;
		{events.floatOp, events.searchDone} = 2'b11;
		events.srchEnable = 1'b1;
		exponent = 13'sh400;
		chanEvent = 8'h08;
		rtcValue = rtcTarget;
		equipIrq[17] = 1'b1;
		hold(1);
		{events, exponent, chanEvent, rtcValue} = '0;
		service(CIC_CODE_OVF);
		service(CIC_CODE_DIV);
		service(CIC_CODE_EXP);
		service(12'h011);
		pulse(I_CLRIRQ, 12'h002);
		service(12'h011);
		equipIrq[17] = 1'b0;
		selectClear = 8'h02;
		hold(1);
		selectClear = 8'h00;
		service(CIC_CODE_CHAN | 12'h003);
		pulse(I_CLRIRQ, 12'h008);
		service(CIC_CODE_SRCH);
		service(CIC_CODE_RTC);
		quiet();
		$display("test priority done");
		events.decimalOp = 1'b1;
		decOperand = 24'h00_0283;
		hold(1);
		chk(decFixedOut, 24'h00_0003);
		events = '0;
		hold(1);
		service(CIC_CODE_DEC);
		for (int v = 13; v <= 15; v++) begin
			events.decLoad = 1'b1;
			decLoadValue = 6'(v);
			hold(1);
			events = '0;
			service(CIC_CODE_DEC);
		end
		$display("test decimal done");
		manualSwitch = 1'b1;
		hold(6);
		manualSwitch = 1'b0;
		hold(6);
		pulse(I_EN, 12'h000);
		fetch();
		opcode = 6'h2F;
		fetch();
		chk(req.code, CIC_CODE_MAN);
		fetch();
		chk(req.kind, CIC_ENT_TRAP);
		chk(req.code[5:0], opcode);
		@(negedge mclk);
		chk(seq_u.mem[9], {FILL[23:6], opcode});
		chk(seq_u.mem[8][14:0], progAddr + 15'h0001);
		optionPresent = 8'h04;
		fetch();
		chk(got, 1'b0);
		{opcode, optionPresent} = '0;
		$display("test trap done");
		pulse(I_EN, 12'h000);
		powerOk = 1'b0;
		fetchEnd = 1'b1;
		n = 0;
		while (entryValid !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		if (n == 200) begin
			err_total++;
			wrap_up();
		end
		req = entryReq;
		fetchEnd = 1'b0;
		chk(req.kind, CIC_ENT_PF);
		chk(irqEnabled, 1'b0);
		chk(n >= 20 && n < 40, 1'b1);
		@(negedge mclk);
		chk(seq_u.mem[2][14:0], progAddr);
		n = 0;
		while (powerDown !== 1'b1 && n < 60) begin
			@(negedge mclk);
			n++;
		end
		chk(powerDown, 1'b1);
		$display("test power done");
		wrap_up();
	end
endmodule : tb_top
bind cic_top cic_top_props #(.CHAN_PRESENT(CHAN_PRESENT)) props_u (
	.mclk(mclk), .rst_n(rst_n), .instr(instr), .fetchEnd(fetchEnd),
	.progAddr(progAddr), .entryReq(entryReq), .entryValid(entryValid),
	.senseResult(senseResult), .irqEnabled(irqEnabled));
